/* verilog/timer_pkg.sv */
// Package for the dual counter/timer mode-control block.
// Assumes one system clock and a byte-wide special-function-register bus.
package timer_pkg;

   // Special-function-register address of the mode control register
   localparam logic [7:0] MODE_CTRL_ADDR  = 8'h89;
   localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
   localparam logic [7:0] SFR_UNMAPPED    = 8'h00;

   // Field positions inside the mode control register
   localparam int TIMER1_GATE_BIT    = 7;
   localparam int TIMER1_SOURCE_BIT  = 6;
   localparam int TIMER1_MODE_HI_BIT = 5;
   localparam int TIMER1_MODE_LO_BIT = 4;
   localparam int TIMER0_GATE_BIT    = 3;
   localparam int TIMER0_SOURCE_BIT  = 2;
   localparam int TIMER0_MODE_HI_BIT = 1;
   localparam int TIMER0_MODE_LO_BIT = 0;

   // Counter widths and reset values
   localparam int           COUNT_W     = 16;
   localparam logic [15:0]  COUNT_RESET = 16'h0000;
   localparam int           SYNC_STAGES = 2;

   // Counting modes held in each two-bit mode field
   typedef enum logic [1:0] {
      MODE_13BIT  = 2'b00,
      MODE_16BIT  = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT  = 2'b11
   } timer_mode_t;

   // One read or write request on the special-function-register bus
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;

   // Per-timer settings decoded from the mode control register
   typedef struct packed {
      logic        gate;
      logic        source;
      timer_mode_t mode;
   } timer_cfg_t;

endpackage

/* verilog/timer_helpers.sv */
// Helper modules: pin synchroniser with falling-edge detect, and tick select.
// Assumes pins are asynchronous to clk_in and the prescale tick is on clk_in.
`timescale 1ns/10ps

// Synchronises an external pin and flags its high-to-low transitions
module pin_sync #(
   parameter int STAGES = timer_pkg::SYNC_STAGES
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic pin_in,
   output logic      level_out,
   output logic      fall_out
);
   import timer_pkg::*;

   logic [STAGES-1:0] sync_r;
   logic              last_r;

   // Refuse a chain too short to settle metastability
   if (STAGES < 2)
   begin : g_bad_stages
      $error("pin_sync needs at least two stages");
   end

   // Shift chain; only the last stage is read by logic
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         sync_r <= '0;
         last_r <= 1'b0;
      end
      else
      begin
         sync_r <= {sync_r[STAGES-2:0], pin_in};
         last_r <= sync_r[STAGES-1];
      end
   end

   // Falling edge: sampled high, then sampled low
   assign level_out = sync_r[STAGES-1];
   assign fall_out  = last_r & ~sync_r[STAGES-1];
endmodule

// Picks the increment tick of one timer from its source settings
module tick_select (
   input  wire logic source_in,
   input  wire logic prescale_select_in,
   input  wire logic prescale_tick_in,
   input  wire logic pin_fall_in,
   output logic      tick_out
);
   logic internal_tick;

   // Internal timebase: system clock or prescaled tick
   assign internal_tick = prescale_select_in | prescale_tick_in;
   assign tick_out      = source_in ? pin_fall_in : internal_tick;
endmodule

/* verilog/timer01_mode_control.sv */
// Mode control and counting logic for two counter/timers.
// Assumes run bits, polarity and prescale selects come from registers on clk_in;
// count and interrupt pins are asynchronous.
// Operation
// - Timer 1 gate bit7, source bit6, mode bits5-4; Timer 0 gate bit3.
// - Timer 1 ungated counts whenever its run bit is 1.
// - Timer 1 gated counts only with run set and interrupt input active, unless Timer 0 is split.
// - Timer 1 source 0 counts the internal timebase chosen by its prescale bit.
// - Timer 1 source 1 counts falling edges on its count pin, except while Timer 0 is split.
// - Timer 1 mode 00 is a 13-bit counter.
// - Timer 1 mode 10 is an 8-bit counter auto-reloading on overflow.
// - Timer 1 mode 11 stops and stays inactive.
// - Timer 0 ungated counts whenever its run bit is 1.
// - Timer 0 gated counts only with run set and interrupt input active.
// - Timer 0 source 0 counts the internal timebase chosen by its prescale bit.
// - Timer 0 split gives two 8-bit counters; low byte uses Timer 0 controls.
// - Split high byte counts internal time, runs on Timer 1 run, flags Timer 1.
`timescale 1ns/10ps

module timer01_mode_control (
   input  wire logic                 clk_in,
   input  wire logic                 srst_in,
   input  wire timer_pkg::sfr_req_t  sfr_req_in,
   output logic [7:0]                sfr_rdata_out,
   input  wire logic                 timer0_run_in,
   input  wire logic                 timer1_run_in,
   input  wire logic                 ext_irq_a_polarity_in,
   input  wire logic                 ext_irq_b_polarity_in,
   input  wire logic                 timer0_prescale_select_in,
   input  wire logic                 timer1_prescale_select_in,
   input  wire logic                 prescale_tick_in,
   input  wire logic                 ext_irq_in_a_in,
   input  wire logic                 ext_irq_in_b_in,
   input  wire logic                 timer0_count_pin_in,
   input  wire logic                 timer1_count_pin_in,
   output logic [7:0]                timer_mode_control_out,
   output logic [15:0]               timer0_count_out,
   output logic [15:0]               timer1_count_out,
   output logic                      timer0_overflow_out,
   output logic                      timer1_overflow_flag_out,
   output logic                      timer1_rollover_out
);
   import timer_pkg::*;

   logic [7:0]  timer_mode_control_r;
   logic [7:0]  sfr_rdata_r;
   logic [15:0] count0_r;
   logic [15:0] count1_r;
   logic        ovf0_r;
   logic        flag1_r;
   logic        roll1_r;

   logic        mode_sel;
   logic        mode_wr;
   logic        mode_rd;
   timer_cfg_t  cfg0;
   timer_cfg_t  cfg1;
   logic        irq_a_lvl;
   logic        irq_b_lvl;
   logic        pin0_fall;
   logic        pin1_fall;
   logic        irq_a_active;
   logic        irq_b_active;
   logic        split0;
   logic        en0;
   logic        en1_normal;
   logic        en1;
   logic        source1;
   logic        tick0;
   logic        tick0_hi;
   logic        tick1;
   logic        inc0;
   logic        inc0_hi;
   logic        inc1;
   logic [16:0] step0;
   logic [16:0] step1;
   logic [8:0]  split_lo;
   logic [8:0]  split_hi;
   logic [15:0] count0_nxt;
   logic [15:0] count1_nxt;
   logic        ovf0_nxt;
   logic        ovf0_hi_nxt;
   logic        ovf1_nxt;

   // One counting step of a timer in the given mode, overflow in the top bit
   function automatic logic [16:0] advance(input logic [15:0] c, input timer_mode_t m);
      logic [13:0] s13;
      logic [8:0]  s8;
      s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
      s8  = {1'b0, c[7:0]} + 9'h001;
      case (m)
         MODE_13BIT:  advance = {s13[13], s13[12:5], c[7:5], s13[4:0]};
         MODE_16BIT:  advance = {1'b0, c} + 17'h00001;
         MODE_RELOAD: advance = s8[8] ? {1'b1, c[15:8], c[15:8]} : {1'b0, c[15:8], s8[7:0]};
         default:     advance = {1'b0, c};
      endcase
   endfunction

   // Register decode on the special-function-register bus
   assign mode_sel = (sfr_req_in.addr == MODE_CTRL_ADDR);
   assign mode_wr  = mode_sel & sfr_req_in.wr;
   assign mode_rd  = mode_sel & sfr_req_in.rd;

   // Field split of the mode control register
   assign cfg1.gate   = timer_mode_control_r[TIMER1_GATE_BIT];
   assign cfg1.source = timer_mode_control_r[TIMER1_SOURCE_BIT];
   assign cfg1.mode   = timer_mode_t'({timer_mode_control_r[TIMER1_MODE_HI_BIT],
                                       timer_mode_control_r[TIMER1_MODE_LO_BIT]});
   assign cfg0.gate   = timer_mode_control_r[TIMER0_GATE_BIT];
   assign cfg0.source = timer_mode_control_r[TIMER0_SOURCE_BIT];
   assign cfg0.mode   = timer_mode_t'({timer_mode_control_r[TIMER0_MODE_HI_BIT],
                                       timer_mode_control_r[TIMER0_MODE_LO_BIT]});

   // Synchronisers for interrupt inputs and count pins
   pin_sync u_sync_irq_a (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (ext_irq_in_a_in),
      .level_out (irq_a_lvl),
      .fall_out  ()
   );
   pin_sync u_sync_irq_b (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (ext_irq_in_b_in),
      .level_out (irq_b_lvl),
      .fall_out  ()
   );
   pin_sync u_sync_pin0 (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (timer0_count_pin_in),
      .level_out (),
      .fall_out  (pin0_fall)
   );
   pin_sync u_sync_pin1 (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (timer1_count_pin_in),
      .level_out (),
      .fall_out  (pin1_fall)
   );

   // Interrupt input active per its polarity setting (1 = active high)
   assign irq_a_active = ext_irq_a_polarity_in ? irq_a_lvl : ~irq_a_lvl;
   assign irq_b_active = ext_irq_b_polarity_in ? irq_b_lvl : ~irq_b_lvl;

   // Run and gate enables
   assign split0     = (cfg0.mode == MODE_SPLIT);
   assign en0        = timer0_run_in & (~cfg0.gate | irq_a_active);
   assign en1_normal = timer1_run_in & (~cfg1.gate | irq_b_active);
   // While Timer 0 is split, Timer 1 runs by its mode field alone
   assign en1        = (split0 ? 1'b1 : en1_normal) & (cfg1.mode != MODE_SPLIT);
   // While Timer 0 is split, Timer 1 cannot use external clocking
   assign source1    = cfg1.source & ~split0;

   // Tick sources for each counter
   tick_select u_tick0 (
      .source_in          (cfg0.source),
      .prescale_select_in (timer0_prescale_select_in),
      .prescale_tick_in   (prescale_tick_in),
      .pin_fall_in        (pin0_fall),
      .tick_out           (tick0)
   );
   tick_select u_tick0_hi (
      .source_in          (1'b0),
      .prescale_select_in (timer0_prescale_select_in),
      .prescale_tick_in   (prescale_tick_in),
      .pin_fall_in        (1'b0),
      .tick_out           (tick0_hi)
   );
   tick_select u_tick1 (
      .source_in          (source1),
      .prescale_select_in (timer1_prescale_select_in),
      .prescale_tick_in   (prescale_tick_in),
      .pin_fall_in        (pin1_fall),
      .tick_out           (tick1)
   );

   // Increment strobes
   assign inc0    = en0 & tick0;
   assign inc0_hi = split0 & timer1_run_in & tick0_hi;
   assign inc1    = en1 & tick1;

   // Next counter values
   assign step0    = advance(count0_r, cfg0.mode);
   assign step1    = advance(count1_r, cfg1.mode);
   assign split_lo = {1'b0, count0_r[7:0]} + 9'h001;
   assign split_hi = {1'b0, count0_r[15:8]} + 9'h001;

   assign count0_nxt  = split0 ? {(inc0_hi ? split_hi[7:0] : count0_r[15:8]),
                                  (inc0 ? split_lo[7:0] : count0_r[7:0])}
                               : (inc0 ? step0[15:0] : count0_r);
   assign ovf0_nxt    = inc0 & (split0 ? split_lo[8] : step0[16]);
   assign ovf0_hi_nxt = inc0_hi & split_hi[8];
   assign count1_nxt  = inc1 ? step1[15:0] : count1_r;
   assign ovf1_nxt    = inc1 & step1[16];

   // Mode register and read data
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         timer_mode_control_r <= MODE_CTRL_RESET;
         sfr_rdata_r          <= SFR_UNMAPPED;
      end
      else
      begin
         if (mode_wr)
            timer_mode_control_r <= sfr_req_in.wdata;
         sfr_rdata_r <= mode_rd ? timer_mode_control_r : SFR_UNMAPPED;
      end
   end

   // Counters and overflow pulses
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         count0_r <= COUNT_RESET;
         count1_r <= COUNT_RESET;
         ovf0_r   <= 1'b0;
         flag1_r  <= 1'b0;
         roll1_r  <= 1'b0;
      end
      else
      begin
         count0_r <= count0_nxt;
         count1_r <= count1_nxt;
         ovf0_r   <= ovf0_nxt;
         flag1_r  <= split0 ? ovf0_hi_nxt : ovf1_nxt;
         roll1_r  <= ovf1_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign sfr_rdata_out            = sfr_rdata_r;
   assign timer_mode_control_out   = timer_mode_control_r;
   assign timer0_count_out         = count0_r;
   assign timer1_count_out         = count1_r;
   assign timer0_overflow_out      = ovf0_r;
   assign timer1_overflow_flag_out = flag1_r;
   assign timer1_rollover_out      = roll1_r;
endmodule

/* verification/timer01_mode_control_props.sv */
// Checker for the timer mode-control block, watching its ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module timer01_mode_control_props (
   input wire logic                clk_in,
   input wire logic                srst_in,
   input wire timer_pkg::sfr_req_t sfr_req_in,
   input wire logic [7:0]          sfr_rdata_out,
   input wire logic                timer1_run_in,
   input wire logic                timer1_prescale_select_in,
   input wire logic                ext_irq_a_polarity_in,
   input wire logic                ext_irq_in_a_in,
   input wire logic [7:0]          timer_mode_control_out,
   input wire logic [15:0]         timer0_count_out,
   input wire logic [15:0]         timer1_count_out,
   input wire logic                timer1_rollover_out
);
   import timer_pkg::*;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);
   // Field decode and the conditions of free and gated counting
   wire logic [7:0] m     = timer_mode_control_out;
   wire logic       hit   = sfr_req_in.addr == MODE_CTRL_ADDR;
   wire logic       split = m[1:0] == 2'b11;
   wire logic       free1 = m[7:4] == 4'h1 && !split && timer1_run_in && timer1_prescale_select_in;
   wire logic       held0 = m[3] && !split && ext_irq_in_a_in != ext_irq_a_polarity_in;

   write_visible_a: assert property (sfr_req_in.wr && hit |=> m == $past(sfr_req_in.wdata))
      else $error("mode write lost");
   read_back_a: assert property (sfr_req_in.rd && hit |=> sfr_rdata_out == $past(m))
      else $error("mode read wrong");
   unmapped_read_a: assert property (sfr_req_in.rd && !hit |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   ungated_count_a: assert property (free1 |=> timer1_count_out == $past(timer1_count_out) + 16'h0001)
      else $error("timer1 missed a tick");
   gated_hold_a: assert property (held0 [*3] |=> $stable(timer0_count_out))
      else $error("timer0 counted while gated");
   stop_mode_a: assert property (m[5:4] == 2'b11 |=> $stable(timer1_count_out))
      else $error("timer1 counted while stopped");
   reload_match_a: assert property (m[5:4] == 2'b10 && timer1_rollover_out |->
      timer1_count_out[7:0] == timer1_count_out[15:8])
      else $error("reload value wrong");
   low_bits_held_a: assert property (m[5:4] == 2'b00 |=> $stable(timer1_count_out[7:5]))
      else $error("13-bit count touched bits 7 to 5");

   // Main scenarios reached
   cover property (sfr_req_in.wr && hit);
   cover property (timer1_rollover_out);
   cover property (held0);
endmodule

bind timer01_mode_control timer01_mode_control_props u_props (
   .clk_in(clk_in), .srst_in(srst_in), .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
   .timer1_run_in(timer1_run_in), .timer1_prescale_select_in(timer1_prescale_select_in),
   .ext_irq_a_polarity_in(ext_irq_a_polarity_in), .ext_irq_in_a_in(ext_irq_in_a_in),
   .timer_mode_control_out(timer_mode_control_out), .timer0_count_out(timer0_count_out),
   .timer1_count_out(timer1_count_out), .timer1_rollover_out(timer1_rollover_out)
);

/* verification/ext_pins.sv */
// Model of the external count pins facing the timer block.
// Assumes requests are one-cycle pulses on the block clock.
`timescale 1ns/10ps
module ext_pins (
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   input  wire logic [1:0] fall_req_in,
   output logic      [1:0] pin_out
);
   logic [2:0] low_r [2];

   // A request pulls its pin low for four cycles, long enough to cross the synchroniser
   always_ff @(posedge clk_in)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (srst_in)
            low_r[i] <= 3'd0;
         else if (fall_req_in[i])
            low_r[i] <= 3'd4;
         else if (low_r[i] != 3'd0)
            low_r[i] <= low_r[i] - 3'd1;
      end
   end

   // Pins idle at the pulled-up high level
   assign pin_out = {low_r[1] == 3'd0, low_r[0] == 3'd0};
endmodule

/* verification/timer01_mode_control_test.sv */
// Self-checking bench for the timer mode-control block.
// Assumes the pin model drives both count pins.
`timescale 1ns/10ps
module timer01_mode_control_test;
   import timer_pkg::*;
   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   sfr_req_t    req = '0;
   logic        run0 = 1'b0, run1 = 1'b0, psel1 = 1'b1, irq_a = 1'b0, irq_b = 1'b0, tick = 1'b0;
   logic [1:0]  div = 2'd0, fall_req = 2'd0, pins;
   logic [7:0]  rdata, mode;
   logic [15:0] t0, t1;
   int          bad_count = 0, cmp_count = 0;
   int          ovf0_n = 0, flag1_n = 0, roll1_n = 0;
   logic        ovf0, flag1, roll1;

   // Clock and a prescaled tick every fourth cycle
   initial forever #10 clk_in = ~clk_in;
   always @(posedge clk_in) div <= div + 2'd1;
   always @(posedge clk_in) tick <= div == 2'd0;

   // Overflow pulse counts, cleared by reset
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ovf0_n  <= 0;
         flag1_n <= 0;
         roll1_n <= 0;
      end
      else
      begin
         ovf0_n  <= ovf0_n + ovf0;
         flag1_n <= flag1_n + flag1;
         roll1_n <= roll1_n + roll1;
      end
   end

   timer01_mode_control DUT (
      .clk_in(clk_in), .srst_in(srst_in), .sfr_req_in(req), .sfr_rdata_out(rdata),
      .timer0_run_in(run0), .timer1_run_in(run1), .ext_irq_a_polarity_in(1'b1),
      .ext_irq_b_polarity_in(1'b1), .timer0_prescale_select_in(1'b1), .timer1_prescale_select_in(psel1),
      .prescale_tick_in(tick), .ext_irq_in_a_in(irq_a), .ext_irq_in_b_in(irq_b),
      .timer0_count_pin_in(pins[0]), .timer1_count_pin_in(pins[1]), .timer_mode_control_out(mode),
      .timer0_count_out(t0), .timer1_count_out(t1), .timer0_overflow_out(ovf0),
      .timer1_overflow_flag_out(flag1), .timer1_rollover_out(roll1)
   );
   ext_pins u_pins (.clk_in(clk_in), .srst_in(srst_in), .fall_req_in(fall_req), .pin_out(pins));

   task automatic check(input string name, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic sfr_write(input logic [7:0] a, d);
      @(posedge clk_in);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk_in);
      req <= '0;
   endtask

   task automatic sfr_read(input logic [7:0] a, exp);
      @(posedge clk_in);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk_in);
      req <= '0;
      // Read data stands for the one cycle after the read edge
      #1;
      check("read data", {8'h00, rdata}, {8'h00, exp});
   endtask

   task automatic run(input logic [1:0] r, input int n);
      @(posedge clk_in);
      {run1, run0} <= r;
      repeat (n) @(posedge clk_in);
      {run1, run0} <= 2'b00;
      @(posedge clk_in);
   endtask

   task automatic pulse_pin();
      @(posedge clk_in);
      fall_req <= 2'b10;
      @(posedge clk_in);
      fall_req <= 2'b00;
      repeat (8) @(posedge clk_in);
   endtask

   task automatic reset_dut();
      srst_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      srst_in <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      end_of_test();
   end

   // Test sequence
   initial
   begin
      reset_dut();
      check("mode reset", {8'h00, mode}, 16'h0000);
      sfr_read(MODE_CTRL_ADDR, 8'h00);
      sfr_write(MODE_CTRL_ADDR, 8'hA5);
      sfr_write(8'h8A, 8'hFF);
      sfr_read(MODE_CTRL_ADDR, 8'hA5);
      sfr_read(8'h8A, 8'h00);
      $display("register test done");
      sfr_write(MODE_CTRL_ADDR, 8'h10);
      run(2'b10, 300);
      check("t1 16-bit", t1, 16'h012C);
      sfr_write(MODE_CTRL_ADDR, 8'h90);
      run(2'b10, 10);
      check("t1 gated off", t1, 16'h012C);
      irq_b <= 1'b1;
      repeat (3) @(posedge clk_in);
      run(2'b10, 10);
      check("t1 gated on", t1, 16'h0136);
      psel1 <= 1'b0;
      sfr_write(MODE_CTRL_ADDR, 8'h10);
      run(2'b10, 40);
      check("t1 prescaled", t1, 16'h0140);
      psel1 <= 1'b1;
      sfr_write(MODE_CTRL_ADDR, 8'h50);
      run1 <= 1'b1;
      repeat (3) pulse_pin();
      run1 <= 1'b0;
      @(posedge clk_in);
      check("t1 pin count", t1, 16'h0143);
      sfr_write(MODE_CTRL_ADDR, 8'h30);
      run(2'b10, 10);
      check("t1 stopped", t1, 16'h0143);
      reset_dut();
      sfr_write(MODE_CTRL_ADDR, 8'h20);
      run(2'b10, 261);
      check("t1 reload", t1, 16'h0005);
      check("t1 rollovers", 16'(roll1_n), 16'h0001);
      check("t1 flag pulses", 16'(flag1_n), 16'h0001);
      check("t0 overflows", 16'(ovf0_n), 16'h0000);
      reset_dut();
      run(2'b10, 40);
      check("t1 13-bit", t1, 16'h0108);
      $display("timer1 test done");
      reset_dut();
      sfr_write(MODE_CTRL_ADDR, 8'h01);
      run(2'b01, 300);
      check("t0 16-bit", t0, 16'h012C);
      sfr_write(MODE_CTRL_ADDR, 8'h09);
      run(2'b01, 10);
      check("t0 gated off", t0, 16'h012C);
      reset_dut();
      sfr_write(MODE_CTRL_ADDR, 8'h13);
      run(2'b11, 300);
      check("t0 split", t0, 16'h2C2C);
      check("split lo overflows", 16'(ovf0_n), 16'h0001);
      check("split hi flag", 16'(flag1_n), 16'h0001);
      check("split t1 rollovers", 16'(roll1_n), 16'h0000);
      $display("timer0 test done");
      end_of_test();
   end
endmodule
